// ==== src/mdsc_ctrl.sv ====
// control port top: interface choice, track/reset filter, acquisition
`timescale 1ns/1ps
`include "mdsc_defines.svh"
// How it works
// (R1) five-bit index picks one of 32
// (R2) acquire-all samples every channel together
// (R3) one low pin: select or frame
// (R4) host pairs load strobe with select
// (R5) offset select targets offset channel
// (R6) host keeps serial clock at 20MHz; the bench host runs a 64 ns period
// (R7) input bit caught on falling edge
// (R8) readback bit driven on rising edge
// (R9) choice low parallel, high serial
// (R10) busy low only during acquisition
// (R11) track high: acquire when addressed
// (R12) track low: pass input, acquire rise
// (R13) 50-150ns low pulse resets everything
// (R14) pulled-down inputs default low
// (R15) pulled-up inputs default high
// (R16) short glitch ignored, long is track
// (R17) all code registers zero after reset
// (R18) two mode bits lead serial word
// (R19) busy low until acquisition completes
// (R20) 33 code registers incl offset
module mdsc_ctrl import mdsc_pkg::*; #(
	parameter int ACQ_CYC = `MDSC_ACQ_CYC_DEF
) (
	input  wire logic        i_core_clk,      // core clock 125 MHz
	input  wire logic        i_rstn,          // sync reset, active low
	input  wire logic        i_sclk,          // serial clock, link domain
	input  wire logic        i_sel_frame_n,   // select / frame sync, low
	input  wire logic        i_sdi,           // serial data in
	output logic             o_sdo,           // serial readback data
	output logic             o_sdo_oe,        // readback drive enable
	input  wire logic [4:0]  i_channel_index, // parallel channel index
	input  wire logic        i_acq_all,       // acquire all channels
	input  wire logic        i_load_n,        // parallel load strobe, low
	input  wire logic        i_offs_sel,      // offset channel select
	input  wire logic        i_interface_choice, // low parallel, high serial
	input  wire logic        i_track_rst_n,   // track / reset input
	input  wire logic [13:0] i_sample_input_voltage, // digitised input
	output logic             o_busy_n,        // acquisition indicator, low
	output logic             o_route_direct,  // output stage follows input
	output logic [4:0]       o_active_ch,     // channel being served
	output logic             o_active_offs,   // offset channel being served
	output logic [13:0]      o_code,          // code at the last serial word's channel
	output logic [13:0]      o_span_shift_output // offset channel code
);
	localparam int RMIN = `MDSC_RST_MIN_CYC; // shortest reset pulse, cycles
	localparam int RMAX = `MDSC_RST_MAX_CYC; // longest reset pulse, cycles

	// code register address of a request: offset channel or indexed channel
	function automatic logic [5:0] mdsc_addr(input mdsc_req_t r);
		if (r.offs)
			return `MDSC_OFFS_ADDR; // [R5]
		else
			return {1'b0, r.index}; // [R1]
	endfunction : mdsc_addr

	// true for the two modes that start an acquisition
	function automatic logic mdsc_is_acq(input logic [1:0] m);
		return m == `MDSC_MODE_ACQUIRE || m == `MDSC_MODE_ALL;
	endfunction : mdsc_is_acq

	// pin synchronisers; undriven pins arrive at their pull levels
	// every pin read by the core domain except i_rstn passes two flops first; the serial link takes its pins directly
	logic [1:0]  s_trk;    // track/reset [R15]
	logic [1:0]  s_sel;    // select / frame
	logic [1:0]  s_load;   // load strobe [R14]
	logic [1:0]  s_choice; // interface choice [R14]
	logic [1:0]  s_all;    // acquire all [R14]
	logic [1:0]  s_offs;   // offset select [R14]
	logic [1:0]  s_tgl;    // word-ready flag from the link domain
	logic [4:0]  s_idx0;   // channel index, first flop
	logic [4:0]  s_idx1;   // channel index, second flop
	logic [13:0] s_vin0;   // digitised input, first flop
	logic [13:0] s_vin1;   // digitised input, second flop
	always_ff @(posedge i_core_clk) begin
		s_trk    <= {s_trk[0], i_track_rst_n};
		s_sel    <= {s_sel[0], i_sel_frame_n};
		s_load   <= {s_load[0], i_load_n};
		s_choice <= {s_choice[0], i_interface_choice};
		s_all    <= {s_all[0], i_acq_all};
		s_offs   <= {s_offs[0], i_offs_sel};
		s_idx0   <= i_channel_index;
		s_idx1   <= s_idx0;
		s_vin0   <= i_sample_input_voltage;
		s_vin1   <= s_vin0;
	end

	// low-pulse width counter on track/reset
	// counts synchronised low cycles and saturates, so a long low
	// level is still told apart from a reset pulse when it ends
	logic [7:0] low_cnt;   // low cycles so far
	logic       trk_d;     // synchronised level, one cycle late
	logic       pulse_rst; // one-cycle reset request
	logic       track_low; // held low past the reset window
	always_ff @(posedge i_core_clk) begin
		trk_d <= s_trk[1];
		if (!i_rstn)
			low_cnt <= 8'h00;
		else if (!s_trk[1])
			low_cnt <= (low_cnt == 8'hff) ? low_cnt : low_cnt + 8'h01;
		else
			low_cnt <= 8'h00;
	end
	// the pulse is judged when it ends, on the synchronised rise
	// reset only for a pulse in window; shorter is glitch [R13] [R16]
	assign pulse_rst = s_trk[1] && !trk_d && low_cnt >= 8'(RMIN) && low_cnt <= 8'(RMAX);
	// track once low longer than the reset window [R16]
	assign track_low = !s_trk[1] && low_cnt > 8'(RMAX);

	// pin reset and pulse reset act alike on the sequencer, code memory and outputs; low_cnt and par_act_d take the pin reset only
	logic soft_rstn;
	assign soft_rstn = i_rstn && !pulse_rst;

	// serial link in its own domain
	// only the ready flag is synchronised; the word is stable by then
	// and the readback code is stable before a frame starts
	logic [`MDSC_WORD_W-1:0] ser_word;
	logic                    ser_tgl;
	logic [13:0]             rdata;
	mdsc_ser_link u_link (
		.i_sclk     (i_sclk),
		.i_frame_n  (i_sel_frame_n | ~i_interface_choice), // [R3] [R9]
		.i_sdi      (i_sdi),
		.i_rb_code  (rdata),
		.o_sdo      (o_sdo),
		.o_sdo_oe   (o_sdo_oe),
		.o_word     (ser_word),
		.o_word_tgl (ser_tgl)
	);
	// word-ready flag into the core domain, two flops
	always_ff @(posedge i_core_clk) begin
		s_tgl <= {s_tgl[0], ser_tgl};
	end
	// edge detector on the second flop only
	logic tgl_d;
	always_ff @(posedge i_core_clk) begin
		tgl_d <= s_tgl[1];
	end

	// decode serial word: mode bits first, then index, then code [R18]
	// the word carries no offset bit, so the offset channel is parallel only
	mdsc_req_t ser_req;
	always_comb begin
		ser_req.mode  = ser_word[`MDSC_WORD_W-1 -: `MDSC_MODE_W]; // [R18]
		ser_req.offs  = 1'b0;
		ser_req.index = ser_word[`MDSC_CODE_W +: `MDSC_IDX_W];
		ser_req.code  = ser_word[`MDSC_CODE_W-1:0];
	end

	// a word is taken once, on the rising edge of its ready flag;
	// the word itself stays put until the last bit of the next frame
	logic ser_ev;
	assign ser_ev = s_choice[1] && s_tgl[1] && !tgl_d;

	// parallel: strobe and select low together [R4]
	// the request is taken once, when both first meet low;
	// index and selects travel through flops of the same depth
	logic par_act;   // strobe and select both low
	logic par_act_d; // same, one cycle late
	logic par_ev;    // first cycle of a parallel access
	assign par_act = !s_load[1] && !s_sel[1] && !s_choice[1]; // [R3] [R9]
	always_ff @(posedge i_core_clk) begin
		par_act_d <= i_rstn ? par_act : 1'b0;
	end
	assign par_ev = par_act && !par_act_d;
	mdsc_req_t par_req;
	always_comb begin
		par_req.mode  = s_all[1] ? `MDSC_MODE_ALL : `MDSC_MODE_ACQUIRE; // [R2]
		par_req.offs  = s_offs[1]; // [R5]
		par_req.index = s_idx1;    // [R1]
		par_req.code  = '0;
	end

	// pick active request
	// only one interface is live at a time, chosen by the pin
	// a request that arrives while busy is dropped
	mdsc_req_t req;
	logic      req_ev;
	assign req    = s_choice[1] ? ser_req : par_req;
	assign req_ev = ser_ev || par_ev;

	// acquisition sequencer
	// an acquisition lasts ACQ_CYC cycles from its first busy cycle
	// to its last; the code is written on the last one
	mdsc_state_t state;
	logic [15:0] acq_cnt;
	mdsc_req_t   cur;

	// start conditions for the status flops; go_idle also drives the sequencer
	// go_idle: an acquiring request taken while idle
	// go_acq: the cycle in which the sequencer enters acquisition
	logic        go_idle;
	logic        go_acq;
	assign go_idle = state == MDSC_IDLE && req_ev && mdsc_is_acq(req.mode);
	assign go_acq  = (go_idle && !track_low) || (state == MDSC_TRACK && s_trk[1]); // [R11] [R12]

	// sequencer: idle, track while the pin is held low, acquire
	always_ff @(posedge i_core_clk) begin
		if (!soft_rstn) begin
			state   <= MDSC_IDLE;
			acq_cnt <= 16'h0000;
			cur     <= '0;
		end else begin
			case (state)
				MDSC_IDLE: begin
					if (go_idle) begin
						cur     <= req;
						acq_cnt <= 16'h0000;
						state   <= track_low ? MDSC_TRACK : MDSC_ACQ; // [R11] [R12]
					end
				end
				MDSC_TRACK: begin
					if (s_trk[1])
						state <= MDSC_ACQ; // [R12]
				end
				MDSC_ACQ: begin
					if (acq_cnt == 16'(ACQ_CYC - 1))
						state <= MDSC_IDLE; // [R19]
					else
						acq_cnt <= acq_cnt + 16'h0001;
				end
				default: state <= MDSC_IDLE;
			endcase
		end
	end

	// memory write: direct code writes or end of acquisition [R20]
	logic        we;     // write one code register
	logic        we_all; // write every output channel
	logic [5:0]  waddr;  // write address
	logic [5:0]  raddr;  // readback address
	logic [13:0] wdata;
	logic        acq_done;
	// last cycle of an acquisition: the sampled input is stored now
	// and the converter takes the output stage back next cycle
	assign acq_done = state == MDSC_ACQ && acq_cnt == 16'(ACQ_CYC - 1);
	always_comb begin
		we     = 1'b0;
		we_all = 1'b0;
		waddr  = mdsc_addr(cur); // [R5]
		wdata  = s_vin1;
		if (acq_done) begin
			we_all = cur.mode == `MDSC_MODE_ALL && !cur.offs; // [R2]
			we     = !we_all;
		end else if (state == MDSC_IDLE && ser_ev && req.mode == `MDSC_MODE_WRITE) begin
			we    = 1'b1;
			waddr = mdsc_addr(req); // [R5]
			wdata = req.code;
		end
	end
	// readback and the code output follow the last serial word's index
	// the index only moves when a new word is complete
	always_comb begin
		raddr = mdsc_addr(ser_req);
	end

	// 33 code words; read data come from a register, so the
	// code output lags a change of readback address by two cycles
	mdsc_code_mem u_mem (
		.i_core_clk (i_core_clk),
		.i_clr      (!soft_rstn), // [R17]
		.i_we       (we),
		.i_we_all   (we_all),
		.i_waddr    (waddr),
		.i_wdata    (wdata),
		.i_raddr    (raddr),
		.o_rdata    (rdata)
	);

	// offset channel copy kept for its own output
	// it follows every acquired write to the offset address; serial writes cannot reach it
	always_ff @(posedge i_core_clk) begin
		if (!soft_rstn)
			o_span_shift_output <= `MDSC_CODE_RST; // [R17]
		else if ((we || acq_done) && waddr == `MDSC_OFFS_ADDR)
			o_span_shift_output <= wdata;
	end

	// status outputs
	// busy is set on the cycle that enters acquisition, and routing on that cycle or, via track, on the first track cycle,
	// so busy stays low exactly ACQ_CYC cycles and the served channel
	// is already shown when busy falls
	always_ff @(posedge i_core_clk) begin
		if (!soft_rstn) begin
			o_busy_n       <= 1'b1;
			o_route_direct <= 1'b0;
			o_active_ch    <= 5'h00;
			o_active_offs  <= 1'b0;
			o_code         <= `MDSC_CODE_RST;
		end else begin
			o_busy_n       <= !(go_acq || (state == MDSC_ACQ && !acq_done)); // [R10] [R19]
			o_route_direct <= go_acq || (state != MDSC_IDLE && !acq_done); // [R12] [R19]
			o_active_ch    <= go_idle ? req.index : cur.index;
			o_active_offs  <= go_idle ? req.offs : cur.offs;
			o_code         <= rdata;
		end
	end
endmodule : mdsc_ctrl

// ==== src/mdsc_defines.svh ====
// timing, width and reset constants for the converter control port
`ifndef MDSC_DEFINES_SVH
`define MDSC_DEFINES_SVH
`define MDSC_CORE_MHZ        125
`define MDSC_RST_MIN_NS      50
`define MDSC_RST_MAX_NS      150
`define MDSC_RST_MIN_CYC     ((`MDSC_RST_MIN_NS * `MDSC_CORE_MHZ + 999) / 1000)
`define MDSC_RST_MAX_CYC     ((`MDSC_RST_MAX_NS * `MDSC_CORE_MHZ) / 1000)
`define MDSC_ACQ_CYC_DEF     16
`define MDSC_CODE_W          14
`define MDSC_IDX_W           5
`define MDSC_NUM_CH          32
`define MDSC_MODE_W          2
`define MDSC_WORD_W          (`MDSC_MODE_W + `MDSC_IDX_W + `MDSC_CODE_W)
`define MDSC_OFFS_ADDR       6'h20
`define MDSC_MODE_WRITE      2'h0
`define MDSC_MODE_ACQUIRE    2'h1
`define MDSC_MODE_READ       2'h2
`define MDSC_MODE_ALL        2'h3
`define MDSC_CODE_RST        14'h0000
`endif

// ==== src/mdsc_pkg.sv ====
// types shared by the converter control port files
package mdsc_pkg;
	// one decoded request from either interface
	typedef struct packed {
		logic [1:0]  mode;   // write, acquire, read, acquire-all
		logic        offs;   // offset channel target
		logic [4:0]  index;  // channel index, bit 4 msb
		logic [13:0] code;   // converter code
	} mdsc_req_t;
	typedef enum logic [1:0] {MDSC_IDLE, MDSC_TRACK, MDSC_ACQ} mdsc_state_t;
endpackage : mdsc_pkg

// ==== src/mdsc_code_mem.sv ====
// code memory: 33 converter code registers with registered read
`timescale 1ns/1ps
`include "mdsc_defines.svh"
module mdsc_code_mem #(
	parameter int W = `MDSC_CODE_W,
	parameter int D = `MDSC_NUM_CH + 1
) (
	input  wire logic                 i_core_clk, // core clock
	input  wire logic                 i_clr,      // clear all words, sync
	input  wire logic                 i_we,       // write one word
	input  wire logic                 i_we_all,   // write all output words
	input  wire logic [5:0]           i_waddr,    // write address
	input  wire logic [W-1:0]         i_wdata,    // write data
	input  wire logic [5:0]           i_raddr,    // read address
	output logic      [W-1:0]         o_rdata     // read data, registered
);
	logic [W-1:0] mem [D];

	// writes, clear wins
	always_ff @(posedge i_core_clk) begin
		for (int k = 0; k < D; k++) begin
			if (i_clr)
				mem[k] <= W'(`MDSC_CODE_RST);
			else if ((i_we && i_waddr == 6'(k)) || (i_we_all && k < `MDSC_NUM_CH))
				mem[k] <= i_wdata;
		end
	end

	// registered read
	always_ff @(posedge i_core_clk) begin
		if (i_clr)
			o_rdata <= W'(`MDSC_CODE_RST);
		else
			o_rdata <= mem[i_raddr];
	end
endmodule : mdsc_code_mem

// ==== src/mdsc_ser_link.sv ====
// serial link shifter on the serial clock, word handed over by a ready flag
`timescale 1ns/1ps
`include "mdsc_defines.svh"
module mdsc_ser_link #(
	parameter int WW = `MDSC_WORD_W,
	parameter int CW = `MDSC_CODE_W
) (
	input  wire logic          i_sclk,     // serial clock
	input  wire logic          i_frame_n,  // frame sync, active low
	input  wire logic          i_sdi,      // serial data in
	input  wire logic [CW-1:0] i_rb_code,  // readback code, stable before frame
	output logic               o_sdo,      // serial data out
	output logic               o_sdo_oe,   // readback drive enable
	output logic [WW-1:0]      o_word,     // last complete word
	output logic               o_word_tgl  // high from word end to next bit
);
	logic [WW-1:0] shift;
	logic [5:0]    cnt;
	logic [CW-1:0] rb_sh;

	// capture on falling edge; frame high restarts the word
	always_ff @(negedge i_sclk or posedge i_frame_n) begin
		if (i_frame_n) begin
			shift <= '0;
			cnt   <= 6'h00;
		end else begin
			shift <= {shift[WW-2:0], i_sdi}; // [R7]
			cnt   <= (cnt == 6'(WW - 1)) ? 6'h00 : cnt + 6'h01;
		end
	end

	// complete word handed over with a level flag; the flag needs no reset,
	// it is rewritten on every falling edge and the core sees its rise
	always_ff @(negedge i_sclk) begin
		o_word_tgl <= !i_frame_n && cnt == 6'(WW - 1);
		if (!i_frame_n && cnt == 6'(WW - 1))
			o_word <= {shift[WW-2:0], i_sdi};
	end

	// readback: code loaded on the first rising edge, then shifted
	always_ff @(posedge i_sclk or posedge i_frame_n) begin
		if (i_frame_n) begin
			rb_sh    <= '0;
			o_sdo    <= 1'b0;
			o_sdo_oe <= 1'b0;
		end else if (!o_sdo_oe) begin
			o_sdo    <= i_rb_code[CW-1]; // [R8]
			rb_sh    <= {i_rb_code[CW-2:0], 1'b0};
			o_sdo_oe <= 1'b1;
		end else begin
			o_sdo    <= rb_sh[CW-1]; // [R8]
			rb_sh    <= {rb_sh[CW-2:0], 1'b0};
		end
	end
endmodule : mdsc_ser_link

// ==== sim/mdsc_props.sv ====
// checker for the converter control port
`timescale 1ns/1ps
module mdsc_props (
	input wire logic        i_core_clk,             // clock
	input wire logic        i_rstn,                 // reset
	input wire logic        i_sclk,                 // link clock
	input wire logic        i_sel_frame_n,          // frame
	input wire logic        i_interface_choice,     // choice
	input wire logic        i_track_rst_n,          // track
	input wire logic [13:0] i_sample_input_voltage, // input
	input wire logic        o_sdo,                  // readback
	input wire logic        o_sdo_oe,               // drive
	input wire logic        o_busy_n,               // busy
	input wire logic        o_route_direct,         // route
	input wire logic [4:0]  o_active_ch,            // channel
	input wire logic        o_active_offs,          // offset
	input wire logic [13:0] o_span_shift_output     // offset code
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn);
	// acquisition timing and routing
	busy_len_a: assert property ($fell(o_busy_n) |-> !o_busy_n [*8] ##[1:12] o_busy_n)
		else $error("busy low time wrong");
	route_acq_a: assert property (!o_busy_n |-> o_route_direct)
		else $error("route not direct while busy");
	ch_hold_a: assert property (!o_busy_n && !$past(o_busy_n) |->
		$stable({o_active_offs, o_active_ch})) else $error("channel moved in acquisition");
	offs_load_a: assert property ($rose(o_busy_n) && o_active_offs |->
		##[0:2] o_span_shift_output == i_sample_input_voltage) else $error("offset not loaded");
	trk_start_a: assert property ($fell(o_busy_n) |-> $past(i_track_rst_n, 3))
		else $error("acquire while track low");
	// readback driver
	sdo_edge_a: assert property (o_sdo_oe && $past(o_sdo_oe) && $changed(o_sdo) |->
		$rose(i_sclk)) else $error("readback moved off rising edge");
	sdo_idle_a: assert property (i_sel_frame_n [*4] |-> !o_sdo_oe)
		else $error("readback driven out of frame");
	par_quiet_a: assert property (!i_interface_choice [*4] |-> !o_sdo_oe)
		else $error("readback driven in parallel mode");
	busy_offs_c: cover property ($fell(o_busy_n) && o_active_offs);
	route_c: cover property (o_route_direct && o_busy_n);
	sdo_c: cover property (o_sdo_oe && $rose(i_sclk));
endmodule : mdsc_props
bind mdsc_ctrl mdsc_props u_props (
	.i_core_clk             (i_core_clk),
	.i_rstn                 (i_rstn),
	.i_sclk                 (i_sclk),
	.i_sel_frame_n          (i_sel_frame_n),
	.i_interface_choice     (i_interface_choice),
	.i_track_rst_n          (i_track_rst_n),
	.i_sample_input_voltage (i_sample_input_voltage),
	.o_sdo                  (o_sdo),
	.o_sdo_oe               (o_sdo_oe),
	.o_busy_n               (o_busy_n),
	.o_route_direct         (o_route_direct),
	.o_active_ch            (o_active_ch),
	.o_active_offs          (o_active_offs),
	.o_span_shift_output    (o_span_shift_output)
);

// ==== sim/mdsc_host.sv ====
// serial host model driving frames into the link
`timescale 1ns/1ps
module mdsc_host (
	output logic      o_sclk,    // link clock
	output logic      o_frame_n, // frame sync
	output logic      o_sdi,     // data out
	input  wire logic i_sdo      // readback in
);
	logic [20:0] rx;
	// idle: clock high and still, data at pull-up level
	initial begin
		o_sclk = 1'b1;
		o_frame_n = 1'b1;
		o_sdi = 1'b1;
	end
	// one word msb first, 64 ns period
	task automatic frame(input logic [20:0] w);
		#3 o_frame_n = 1'b0;
		for (int k = 20; k >= 0; k--) begin
			o_sdi = w[k];
			#32 o_sclk = 1'b0;
			rx = {rx[19:0], i_sdo};
			#32 o_sclk = 1'b1;
		end
		#16 o_frame_n = 1'b1;
		o_sdi = 1'b1;
	endtask : frame
endmodule : mdsc_host

// ==== sim/tb_multichannel_dac_sha_control_port.sv ====
// bench for the converter control port
`timescale 1ns/1ps
module tb_multichannel_dac_sha_control_port;
	logic        clk = 1'b0, rstn = 1'b0, psel_n = 1'b1, load_n = 1'b1;
	logic        offs = 1'b0, all = 1'b0, choice = 1'b0, trk = 1'b1;
	logic [4:0]  idx = 5'h00;
	logic [13:0] sample_input_voltage = 14'h0000;
	logic [13:0] code, span;
	logic        sclk, fr_n, sdi, sdo, oe, busy_n, route, aoffs;
	logic [4:0]  ach;
	int          err_total = 0;
	int          n_tests = 0;
	int          n;
	wire         sel_n = choice ? fr_n : psel_n;
	always #4 clk = ~clk;
	mdsc_host host (.o_sclk(sclk), .o_frame_n(fr_n), .o_sdi(sdi), .i_sdo(sdo));
	mdsc_ctrl #(.ACQ_CYC(16)) uut (.i_core_clk(clk), .i_rstn(rstn), .i_sclk(sclk),
		.i_sel_frame_n(sel_n), .i_sdi(sdi), .o_sdo(sdo), .o_sdo_oe(oe), .i_channel_index(idx),
		.i_acq_all(all), .i_load_n(load_n), .i_offs_sel(offs), .i_interface_choice(choice),
		.i_track_rst_n(trk), .i_sample_input_voltage(sample_input_voltage), .o_busy_n(busy_n),
		.o_route_direct(route), .o_active_ch(ach), .o_active_offs(aoffs), .o_code(code),
		.o_span_shift_output(span));
	task automatic cmp(input logic [13:0] got, input logic [13:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("Error %0t: got %h want %h", $time, got, exp);
		end
	endtask : cmp
	// bounded wait at falling edges for a busy level
	task automatic wait_busy(input logic lvl);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (busy_n !== lvl && n < 99);
		cmp(14'(busy_n), 14'(lvl));
	endtask : wait_busy
	// strobe with select held until acquisition starts
	task automatic par_acq(input logic [4:0] i, input logic o, input logic a, input logic [13:0] v);
		@(posedge clk);
		{idx, offs, all, sample_input_voltage, psel_n, load_n} <= {i, o, a, v, 2'h0};
		wait_busy(1'b0);
		cmp(14'(route), 14'h1);
		if (!a) cmp(14'(ach), 14'(i));
		cmp(14'(aoffs), 14'(o));
		@(posedge clk);
		{psel_n, load_n, all} <= 3'h6;
		wait_busy(1'b1);
		cmp(n[13:0], 14'h10);
		if (o) cmp(span, v);
	endtask : par_acq
	// address while tracking, acquire on rise
	task automatic track_acq();
		@(posedge clk);
		trk <= 1'b0;
		repeat (30) @(posedge clk);
		{idx, sample_input_voltage, psel_n, load_n} <= {5'h03, 14'h0f0f, 2'h0};
		repeat (30) @(posedge clk);
		{psel_n, load_n, trk} <= 3'h7;
		cmp(14'(busy_n), 14'h1);
		cmp(14'(route), 14'h1);
		wait_busy(1'b0);
		wait_busy(1'b1);
	endtask : track_acq
	task automatic ser(input logic [20:0] w);
		host.frame(w);
		repeat (12) @(posedge clk);
	endtask : ser
	task automatic rd(input logic [4:0] c, input logic [13:0] e);
		ser({2'h2, c, 14'h0000});
		cmp(code, e);
	endtask : rd
	task automatic pulse(input int w);
		@(posedge clk);
		trk <= 1'b0;
		repeat (w) @(posedge clk);
		trk <= 1'b1;
		repeat (8) @(posedge clk);
	endtask : pulse
	task automatic finish_test();
		if (err_total == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test
	// main sequence
	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		@(negedge clk);
		cmp(14'(busy_n), 14'h1);
		cmp(span, 14'h0000);
		par_acq(5'h1f, 1'b0, 1'b0, 14'h1234);
		par_acq(5'h07, 1'b1, 1'b0, 14'h3fff);
		par_acq(5'h00, 1'b0, 1'b1, 14'h0555);
		track_acq();
		choice <= 1'b1;
		rd(5'h1f, 14'h0555);
		rd(5'h03, 14'h0f0f);
		ser({2'h0, 5'h05, 14'h2a5c});
		rd(5'h05, 14'h2a5c);
		cmp(host.rx[19:6], 14'h2a5c);
		sample_input_voltage <= 14'h1111;
		ser({2'h1, 5'h09, 14'h0000});
		wait_busy(1'b1);
		rd(5'h09, 14'h1111);
		sample_input_voltage <= 14'h2222;
		ser({2'h3, 5'h00, 14'h0000});
		wait_busy(1'b1);
		rd(5'h14, 14'h2222);
		pulse(4);
		rd(5'h05, 14'h2222);
		pulse(10);
		rd(5'h05, 14'h0000);
		cmp(span, 14'h0000);
		finish_test();
	end
	initial begin
		#300000;
		err_total++;
		finish_test();
	end
endmodule : tb_multichannel_dac_sha_control_port
